// file: hw/rtc_pkg.sv
// Constants shared by the seconds counter and its alarm logic.
package rtc_pkg;
	localparam int TIME_W = 32;
	localparam int BYTE_W = 8;
	localparam int NUM_BYTES = 4;
	localparam int SEL_W = 2;
	localparam logic [TIME_W-1:0] TIME_RST = 32'h0000_0000;
	localparam logic [TIME_W-1:0] ALARM_RST = 32'hFFFF_FFFF;
	localparam logic [5:0] MIN_LAST = 6'h3B;
	localparam logic [5:0] MIN_RST = 6'h00;
	localparam logic [TIME_W-1:0] TIME_ONE = 32'h0000_0001;
	localparam int TICK_HZ = 1;
endpackage

// file: hw/byte_word_reg.sv
`timescale 1ns/1ns
// A 32-bit word written one byte lane at a time, with a reset value.
module byte_word_reg (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic [rtc_pkg::TIME_W-1:0] rst_val_i,
	input wire logic load_i,
	input wire logic [rtc_pkg::TIME_W-1:0] load_val_i,
	input wire logic wr_i,
	input wire logic [rtc_pkg::SEL_W-1:0] sel_i,
	input wire logic [rtc_pkg::BYTE_W-1:0] data_i,
	output logic [rtc_pkg::TIME_W-1:0] word_o
);
	import rtc_pkg::*;

	genvar g;
	generate
		for (g = 0; g < NUM_BYTES; g++) begin : g_lane
			always_ff @(posedge clk_sys_i) begin
				if (!rst_b_i) begin
					word_o[g*BYTE_W +: BYTE_W] <= rst_val_i[g*BYTE_W +: BYTE_W];
				end else if (wr_i && sel_i == SEL_W'(g)) begin
					word_o[g*BYTE_W +: BYTE_W] <= data_i;
				end else if (load_i) begin
					word_o[g*BYTE_W +: BYTE_W] <= load_val_i[g*BYTE_W +: BYTE_W];
				end
			end
		end
	endgenerate
endmodule

// file: hw/seconds_rtc.sv
`timescale 1ns/1ns
// Seconds counter with alarm, second and minute events.
module seconds_rtc (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic tick_1hz_i,
	input wire logic time_wr_i,
	input wire logic alarm_wr_i,
	input wire logic [rtc_pkg::SEL_W-1:0] byte_sel_i,
	input wire logic [rtc_pkg::BYTE_W-1:0] byte_data_i,
	output logic [rtc_pkg::TIME_W-1:0] time_o,
	output logic [rtc_pkg::TIME_W-1:0] alarm_o,
	output logic alarm_irq_o,
	output logic second_irq_o,
	output logic minute_irq_o
);
	import rtc_pkg::*;

	logic tick_s1_q;
	logic tick_s2_q;
	logic tick_s3_q;
	logic step;
	logic [TIME_W-1:0] time_q;
	logic [TIME_W-1:0] time_d;
	logic [TIME_W-1:0] alarm_q;
	logic [5:0] min_cnt_q;
	logic time_wr_q;

	// Tick comes from another domain: two flops, then edge detect
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			tick_s1_q <= 1'b0;
			tick_s2_q <= 1'b0;
			tick_s3_q <= 1'b0;
		end else begin
			tick_s1_q <= tick_1hz_i;
			tick_s2_q <= tick_s1_q;
			tick_s3_q <= tick_s2_q;
		end
	end

	assign step = tick_s2_q && !tick_s3_q;
	assign time_d = time_q + TIME_ONE;

	byte_word_reg u_time (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.rst_val_i(TIME_RST),
		.load_i(step),
		.load_val_i(time_d),
		.wr_i(time_wr_i),
		.sel_i(byte_sel_i),
		.data_i(byte_data_i),
		.word_o(time_q)
	);

	byte_word_reg u_alarm (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.rst_val_i(ALARM_RST),
		.load_i(1'b0),
		.load_val_i(ALARM_RST),
		.wr_i(alarm_wr_i),
		.sel_i(byte_sel_i),
		.data_i(byte_data_i),
		.word_o(alarm_q)
	);

	// Minute phase is free running; a time write does not realign it
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			min_cnt_q <= MIN_RST;
		end else if (step) begin
			min_cnt_q <= (min_cnt_q == MIN_LAST) ? MIN_RST :
				min_cnt_q + 6'h01;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			time_wr_q <= 1'b0;
		end else begin
			time_wr_q <= step;
		end
	end

	// Events fire one cycle after the count settles on its new value
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			second_irq_o <= 1'b0;
			minute_irq_o <= 1'b0;
			alarm_irq_o <= 1'b0;
		end else begin
			second_irq_o <= time_wr_q;
			minute_irq_o <= time_wr_q && min_cnt_q == MIN_RST;
			// Only on a step, so a partial alarm write cannot fire
			alarm_irq_o <= time_wr_q && time_q == alarm_q;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			time_o <= TIME_RST;
			alarm_o <= ALARM_RST;
		end else begin
			time_o <= time_q;
			alarm_o <= alarm_q;
		end
	end

	property p_count_step;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(step && !time_wr_i) |=> time_q == $past(time_q) + TIME_ONE;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("seconds count did not advance by one");

	property p_second;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		step |-> ##2 second_irq_o;
	endproperty
	a_second: assert property (p_second)
		else $error("seconds event missing");

	property p_second_only;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		second_irq_o |-> $past(step, 2);
	endproperty
	a_second_only: assert property (p_second_only)
		else $error("seconds event without a tick");

	property p_alarm;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(time_wr_q && time_q == alarm_q) |=> alarm_irq_o;
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("alarm match not flagged");

	property p_alarm_cause;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		alarm_irq_o |-> $past(time_q) == $past(alarm_q) && second_irq_o;
	endproperty
	a_alarm_cause: assert property (p_alarm_cause)
		else $error("alarm without a match");

	property p_alarm_reset;
		@(posedge clk_sys_i)
		!rst_b_i |=> alarm_q == ALARM_RST;
	endproperty
	a_alarm_reset: assert property (p_alarm_reset)
		else $error("alarm value not all ones after reset");

	// Phase leaves its last count on the sixtieth step since reset
	property p_minute;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		minute_irq_o |-> second_irq_o && $past(min_cnt_q, 2) == MIN_LAST;
	endproperty
	a_minute: assert property (p_minute)
		else $error("minute event off its boundary");

	property p_minute_due;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(second_irq_o && $past(min_cnt_q, 2) == MIN_LAST) |-> minute_irq_o;
	endproperty
	a_minute_due: assert property (p_minute_due)
		else $error("minute event missing on its boundary");

	property p_byte_write;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		alarm_wr_i |=> alarm_q[$past(byte_sel_i)*BYTE_W +: BYTE_W]
			== $past(byte_data_i);
	endproperty
	a_byte_write: assert property (p_byte_write)
		else $error("alarm byte write not stored");

	// A byte write wins over a same-cycle step for its own lane
	property p_time_byte;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		time_wr_i |=> time_q[$past(byte_sel_i)*BYTE_W +: BYTE_W]
			== $past(byte_data_i);
	endproperty
	a_time_byte: assert property (p_time_byte)
		else $error("time byte write not stored");

	// Count moves only on a step or a write
	property p_time_hold;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		(!step && !time_wr_i) |=> $stable(time_q);
	endproperty
	a_time_hold: assert property (p_time_hold)
		else $error("seconds count changed without a tick");

	// All ones stays put until software writes, so no early alarm
	property p_alarm_steady;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		!alarm_wr_i |=> $stable(alarm_q);
	endproperty
	a_alarm_steady: assert property (p_alarm_steady)
		else $error("alarm value changed without a write");

	property p_second_pulse;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		second_irq_o |=> !second_irq_o;
	endproperty
	a_second_pulse: assert property (p_second_pulse)
		else $error("seconds event longer than one cycle");

	// Outputs are plain registered copies, one cycle behind
	property p_out_follow;
		@(posedge clk_sys_i) disable iff (!rst_b_i)
		time_o == $past(time_q) && alarm_o == $past(alarm_q);
	endproperty
	a_out_follow: assert property (p_out_follow)
		else $error("time or alarm output not a copy of the value");

	c_second: cover property (@(posedge clk_sys_i) second_irq_o);
	c_minute: cover property (@(posedge clk_sys_i) minute_irq_o);
	c_alarm: cover property (@(posedge clk_sys_i) alarm_irq_o);
	c_wrap: cover property (@(posedge clk_sys_i) step && time_q == ALARM_RST);
	c_lane_wins: cover property (@(posedge clk_sys_i)
		step && time_wr_i);
endmodule

// file: testbench/seconds_rtc_test.sv
// Self-checking bench for the seconds counter with alarm.
`timescale 1ns/1ns
module seconds_rtc_test;
	import rtc_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic tick_1hz_i = 1'b0;
	logic time_wr_i = 1'b0;
	logic alarm_wr_i = 1'b0;
	logic [SEL_W-1:0] byte_sel_i = '0;
	logic [BYTE_W-1:0] byte_data_i = '0;
	logic [TIME_W-1:0] time_o;
	logic [TIME_W-1:0] alarm_o;
	logic alarm_irq_o;
	logic second_irq_o;
	logic minute_irq_o;
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	int nt = 0;
	int n_sec;
	int n_min;
	int n_alm;

	seconds_rtc dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.tick_1hz_i(tick_1hz_i), .time_wr_i(time_wr_i),
		.alarm_wr_i(alarm_wr_i), .byte_sel_i(byte_sel_i),
		.byte_data_i(byte_data_i), .time_o(time_o), .alarm_o(alarm_o),
		.alarm_irq_o(alarm_irq_o), .second_irq_o(second_irq_o),
		.minute_irq_o(minute_irq_o));

	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// About 185 ticks of 10 cycles each; ceiling leaves ample margin
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Tick held 5 cycles each level, wide enough for the synchroniser
	task automatic tick(input logic exp_alm);
		n_sec = 0;
		n_min = 0;
		n_alm = 0;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys_i);
			tick_1hz_i <= (i < 5);
			#1;
			if (second_irq_o === 1'b1) n_sec++;
			if (minute_irq_o === 1'b1) n_min++;
			if (alarm_irq_o === 1'b1) n_alm++;
			// An unknown event bit spoils the seconds count
			if ($isunknown({alarm_irq_o, second_irq_o, minute_irq_o})) n_sec++;
		end
		cmp(n_sec, 1);
		// Minute phase counts ticks since reset, not the time value
		cmp(n_min, ((nt + 1) % 60 == 0));
		cmp(n_alm, exp_alm);
		nt++;
	endtask

	// Four lanes back to back, strobe held high between them
	task automatic wr(input logic alm, input logic [31:0] v);
		n_alm = 0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys_i);
			time_wr_i <= !alm;
			alarm_wr_i <= alm;
			byte_sel_i <= i[1:0];
			byte_data_i <= v[8*i +: 8];
			#1;
			if (alarm_irq_o !== 1'b0) n_alm++;
		end
		@(posedge clk_sys_i);
		time_wr_i <= 1'b0;
		alarm_wr_i <= 1'b0;
		repeat (3) begin
			@(posedge clk_sys_i);
			#1;
			if (alarm_irq_o !== 1'b0) n_alm++;
		end
	endtask

	task automatic t_reset();
		#1;
		cmp(time_o, 32'h0000_0000);
		cmp(alarm_o, 32'hFFFF_FFFF);
		$display("test reset done");
	endtask

	task automatic t_tick();
		tick(1'b0);
		cmp(time_o, 32'h0000_0001);
		$display("test tick done");
	endtask

	task automatic t_bytes();
		wr(1'b0, 32'h1234_5678);
		cmp(time_o, 32'h1234_5678);
		wr(1'b1, 32'hA5C3_0F96);
		cmp(alarm_o, 32'hA5C3_0F96);
		// Alarm set to the present count: no event until the next step
		wr(1'b1, 32'h1234_5678);
		cmp(n_alm, 1'b0);
		cmp(alarm_o, 32'h1234_5678);
		$display("test bytes done");
	endtask

	// Match, then the wrap from all ones back to zero
	task automatic t_alarm();
		wr(1'b1, 32'h1234_5679);
		tick(1'b1);
		cmp(time_o, 32'h1234_5679);
		wr(1'b0, 32'hFFFF_FFFE);
		wr(1'b1, 32'hFFFF_FFFF);
		tick(1'b1);
		tick(1'b0);
		cmp(time_o, 32'h0000_0000);
		$display("test alarm done");
	endtask

	task automatic t_minute();
		for (int i = 0; i < 61; i++) begin
			tick(1'b0);
		end
		cmp(time_o, 32'h0000_003D);
		$display("test minute done");
	endtask

	// Second reset, then a time write on the minute phase keeps alignment
	task automatic t_realign();
		@(posedge clk_sys_i);
		rst_b_i <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		#1;
		nt = 0;
		cmp(time_o, 32'h0000_0000);
		cmp(alarm_o, 32'hFFFF_FFFF);
		for (int i = 0; i < 60; i++) begin
			tick(1'b0);
		end
		cmp(time_o, 32'h0000_003C);
		wr(1'b0, 32'h0000_0E10);
		for (int i = 0; i < 60; i++) begin
			tick(1'b0);
		end
		cmp(time_o, 32'h0000_0E4C);
		$display("test realign done");
	endtask

	initial begin
		repeat (5) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		t_reset();
		t_tick();
		t_bytes();
		t_alarm();
		t_minute();
		t_realign();
		report_and_stop();
	end
endmodule
